/* File: scan_converter_host_control_regs_tb_top.sv */
`default_nettype none
`define CHK(got, exp) \
    begin \
        n_checks++; \
        if ((got) !== (exp)) \
        begin \
            num_errors++; \
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp); \
        end \
    end
// =====
// host and device face each other on link_if; a second device is
// driven by the bench over port_if to reach every register
module scan_converter_host_control_regs_tb_top
    import scan_ctrl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [7:0]  a;     // address
        logic [7:0]  d;     // value written
        logic [7:0]  rexp;  // value read back
        logic [15:0] obs;   // expected settings outputs
    } row_type;
    typedef struct packed {
        logic [7:0] a;      // command byte
        logic [7:0] v;      // value
        logic [5:0] p;      // expected pulses
    } cmd_type;
    logic       clk = 1'b0;
    logic       reset = 1'b1;
    logic       ce_dev = 1'b1;    // enable of the bench-driven device
    logic       mode_done = 1'b0;
    logic       uc_gpo0 = 1'b0;
    logic [1:0] h_addr = 2'h0;
    logic [7:0] h_wdata = 8'h00;
    logic       h_wr = 1'b0;
    logic       h_rd = 1'b0;
    logic [7:0] h_rdata, gpo1, gpo2, v;
    logic [5:0] gain2, acc;
    logic [3:0] flk2;
    logic       tm1, tm2, bars2, centre2, run2, tbl2, cal2, det2, done2;
    wire  logic [5:0] pulses;
    int         num_errors = 0;
    int         n_checks = 0;
    int         n_ccs = 0;
    row_type    rows [10];
    cmd_type    cmds [6];
    wire  logic [15:0] obs = {2'b00, gain2, flk2, 1'b0, centre2, tbl2, bars2};
    scan_ctrl_if link_if ();
    scan_ctrl_if port_if ();
    scan_ctrl_dev scan_ctrl_dev_inst (.I_CLK(clk), .I_RESET(reset), .I_CE(1'b1),
        .bus(link_if), .I_MODE_DONE(1'b0), .I_UC_GPO0(1'b0), .O_GPO(gpo1),
        .O_SAT_GAIN(), .O_FLICKER(), .O_BARS(), .O_CENTRE(), .O_TEST_MODE(tm1),
        .O_UC_RUN(), .O_SWRST(), .O_REDETECT(), .O_RECAL(), .O_TBL_RESET(),
        .O_RECOMPUTE(), .O_TBL_STORE(), .O_CAL_SAMPLE(), .O_DET_SAMPLE(),
        .O_MCAL_TAKE(), .O_MODE_DONE());
    scan_ctrl_host scan_ctrl_host_inst (.I_CLK(clk), .I_RESET(reset), .I_CE(1'b1),
        .i_addr(h_addr), .i_wdata(h_wdata), .i_wr(h_wr), .i_rd(h_rd),
        .o_rdata(h_rdata), .bus(link_if));
    scan_ctrl_dev port_scan_ctrl_dev_inst (.I_CLK(clk), .I_RESET(reset), .I_CE(ce_dev),
        .bus(port_if), .I_MODE_DONE(mode_done), .I_UC_GPO0(uc_gpo0), .O_GPO(gpo2),
        .O_SAT_GAIN(gain2), .O_FLICKER(flk2), .O_BARS(bars2), .O_CENTRE(centre2),
        .O_TEST_MODE(tm2), .O_UC_RUN(run2), .O_SWRST(pulses[5]),
        .O_REDETECT(pulses[4]), .O_RECAL(pulses[3]), .O_TBL_RESET(pulses[2]),
        .O_RECOMPUTE(pulses[1]), .O_TBL_STORE(tbl2), .O_CAL_SAMPLE(cal2),
        .O_DET_SAMPLE(det2), .O_MCAL_TAKE(pulses[0]), .O_MODE_DONE(done2));
    scan_ctrl_asserts scan_ctrl_asserts_inst (.I_CLK(clk), .I_RESET(reset),
        .wr(link_if.wr), .rd(link_if.rd), .addr(link_if.addr), .wdata(link_if.wdata),
        .rdata(link_if.rdata), .ccs_wr(link_if.ccs_wr), .O_GPO(gpo1), .O_TEST_MODE(tm1));
    // 100 MHz clock
    always #5 clk = ~clk;
    // count entry writes and gather command pulses
    always @(posedge clk)
    begin
        if (link_if.ccs_wr === 1'b1) n_ccs++;
        acc <= acc | pulses;
    end
    // =====
    // bus tasks: strobe one cycle, read data the cycle after
    task automatic dw(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        port_if.addr <= a;
        port_if.wdata <= d;
        port_if.wr <= 1'b1;
        @(posedge clk);
        port_if.wr <= 1'b0;
        // one more edge so the registered outputs have settled
        @(posedge clk);
        #1;
    endtask
    task automatic dr(input logic [7:0] a);
        @(posedge clk);
        port_if.addr <= a;
        port_if.rd <= 1'b1;
        @(posedge clk);
        port_if.rd <= 1'b0;
        #1 v = port_if.rdata;
    endtask
    task automatic hw(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        h_addr <= a;
        h_wdata <= d;
        h_wr <= 1'b1;
        @(posedge clk);
        h_wr <= 1'b0;
        #1;
    endtask
    task automatic hr(input logic [1:0] a);
        @(posedge clk);
        h_addr <= a;
        h_rd <= 1'b1;
        @(posedge clk);
        h_rd <= 1'b0;
        #1 v = h_rdata;
    endtask
    // read until the masked bits are clear; bounded
    task automatic poll(input logic hs, input logic [7:0] a, input logic [7:0] m);
        int k;
        for (k = 0; k < 20; k++)
        begin
            if (hs) hr(a[1:0]);
            else dr(a);
            if ((v & m) === 8'h00) break;
        end
        if (k == 20)
        begin
            num_errors++;
            finish_test();
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // =====
    // main sequence
    initial
    begin
        port_if.wr = 1'b0;
        port_if.rd = 1'b0;
        port_if.ccs_wr = 1'b0;
        port_if.addr = 8'h00;
        port_if.wdata = 8'h00;
        acc = 6'h00;
        rows = '{'{8'h2E, 8'h3F, 8'h3F, 16'h3F00}, '{8'h2E, 8'h21, 8'h21, 16'h2100},
            '{8'h2F, 8'hFF, 8'h00, 16'h2100}, '{8'h34, 8'hA5, 8'hA5, 16'h2100},
            '{8'h61, 8'h84, 8'h84, 16'h2184}, '{8'h61, 8'h50, 8'h50, 16'h2150},
            '{8'h60, 8'h84, 8'h84, 16'h2153}, '{8'h50, 8'hFF, 8'h00, 16'h2153},
            '{8'h60, 8'h00, 8'h00, 16'h2150}, '{8'h60, 8'h80, 8'h80, 16'h2152}};
        cmds = '{'{8'h60, 8'h8A, 6'h00}, '{8'h60, 8'h92, 6'h18}, '{8'h60, 8'hA2, 6'h0C},
            '{8'h60, 8'hC2, 6'h02}, '{8'h61, 8'h08, 6'h01}, '{8'h60, 8'h83, 6'h20}};
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        foreach (rows[i])
        begin
            dw(rows[i].a, rows[i].d);
            dr(rows[i].a);
            `CHK(v, rows[i].rexp)
            `CHK(obs, rows[i].obs)
        end
        `CHK(gpo2, 8'hA5)
        dw(ADDR_CMD_HI, 8'hF0);
        `CHK(flk2, FLK_MAX)
        dw(ADDR_GPO_HI, 8'h01);
        `CHK(tm2, 1'b1)
        dw(ADDR_GPO_HI, 8'h00);
        `CHK(tm2, 1'b0)
        // a frozen device ignores a write
        @(posedge clk) ce_dev <= 1'b0;
        dw(ADDR_SAT_LO, 8'h05);
        @(posedge clk) ce_dev <= 1'b1;
        dr(ADDR_SAT_LO);
        `CHK(v, 8'h21)
        $display("test registers done");
        // a command left pending while the controller is off stays put
        dw(ADDR_CMD_LO, 8'h90);
        acc = 6'h00;
        repeat (8) @(posedge clk);
        #1 `CHK(acc, 6'h00)
        dr(ADDR_CMD_LO);
        `CHK(v, 8'h90)
        dw(ADDR_CMD_HI, 8'h00);
        dw(ADDR_CMD_LO, 8'h82);
        `CHK(run2, 1'b1)
        `CHK({cal2, det2}, 2'b11)
        dw(ADDR_CMD_HI, 8'h03);
        `CHK({cal2, det2}, 2'b00)
        dw(ADDR_CMD_HI, 8'h00);
        repeat (4) @(posedge clk);
        #1 `CHK(gpo2, 8'hA4)
        // controller drives bit 0 high through its two sync stages
        @(posedge clk) uc_gpo0 <= 1'b1;
        repeat (4) @(posedge clk);
        #1 `CHK(gpo2, 8'hA5)
        dr(ADDR_GPO_LO);
        `CHK(v, 8'hA5)
        @(posedge clk) mode_done <= 1'b1;
        repeat (5) @(posedge clk);
        mode_done <= 1'b0;
        repeat (10) @(posedge clk);
        #1 `CHK(done2, 1'b1)
        $display("test controller enable done");
        // each command waits for the previous one to self-clear
        foreach (cmds[i])
        begin
            acc = 6'h00;
            dw(cmds[i].a, cmds[i].v);
            poll(1'b0, cmds[i].a,
                cmds[i].v & (cmds[i].a == ADDR_CMD_LO ? SELF_CLR_LO : SELF_CLR_HI));
            `CHK(acc, cmds[i].p)
            if (i == 0) `CHK(done2, 1'b0)
        end
        $display("test commands done");
        // host updates the outputs; a second go while busy is ignored
        hw(HOST_ADDR_DATA, 8'hA5);
        hw(HOST_ADDR_GO, 8'h01);
        poll(1'b1, {6'h00, HOST_ADDR_STAT}, 8'h01);
        `CHK(gpo1, 8'hA4)
        hr(HOST_ADDR_RDAT);
        `CHK(v, 8'h00)
        hw(HOST_ADDR_DATA, 8'h3C);
        hw(HOST_ADDR_GO, 8'h01);
        hw(HOST_ADDR_GO, 8'h01);
        poll(1'b1, {6'h00, HOST_ADDR_STAT}, 8'h01);
        `CHK(gpo1, 8'h3C)
        `CHK(n_ccs, 2)
        hr(HOST_ADDR_RDAT);
        `CHK(v, 8'hA4)
        `CHK(tm1, 1'b0)
        $display("test host updates done");
        finish_test();
    end
endmodule
`default_nettype wire

/* File: scan_ctrl_asserts.sv */
`default_nettype none
// =====
// checker on the host-to-device register link
module scan_ctrl_asserts
    import scan_ctrl_pkg::*;
(
    input  wire logic       I_CLK,
    input  wire logic       I_RESET,
    input  wire logic       wr,
    input  wire logic       rd,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic [7:0] rdata,
    input  wire logic       ccs_wr,
    input  wire logic [7:0] O_GPO,
    input  wire logic       O_TEST_MODE
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (I_RESET);
    // =====
    // helpers
    logic [7:0] ccs_val_r;   // value last sent to the config entry
    logic [7:0] gpo_val_r;   // value last written to the outputs
    wire  logic gpo_wr = wr && (addr == ADDR_GPO_LO);
    wire  logic gpo_rd = rd && (addr == ADDR_GPO_LO);
    wire  logic hi_wr  = wr && (addr == ADDR_GPO_HI) && (wdata != ZERO_BYTE);
    // keep the last values so later writes and reads can be compared with them
    always_ff @(posedge I_CLK)
    begin
        if (I_RESET)
        begin
            ccs_val_r <= ZERO_BYTE;
            gpo_val_r <= ZERO_BYTE;
        end
        else
        begin
            if (ccs_wr) ccs_val_r <= wdata;
            if (gpo_wr) gpo_val_r <= wdata;
        end
    end
    // =====
    // update order and values
    a_entry_first: assert property (gpo_wr |-> $past(ccs_wr, 3))
        else $error("output write not preceded by entry write");
    a_update_walk: assert property (ccs_wr |-> ##1 gpo_rd ##2 gpo_wr)
        else $error("update sequence broken");
    a_same_value: assert property (gpo_wr |-> wdata[7:1] == ccs_val_r[7:1])
        else $error("output value differs from entry value");
    a_read_first: assert property (gpo_wr |-> $past(gpo_rd, 2))
        else $error("output write without read first");
    a_bit0_kept: assert property (gpo_wr |-> wdata[0] == rdata[0])
        else $error("output bit 0 not preserved");
    // pins and readback
    // register takes the write, the pin flops follow one edge later
    a_pins_follow: assert property (gpo_wr |-> ##2 O_GPO == $past(wdata, 2))
        else $error("pins do not follow written value");
    a_pins_hold: assert property (!$stable(O_GPO) |-> $past(gpo_wr, 2))
        else $error("pins changed without a write");
    a_readback: assert property (gpo_rd |=> rdata == gpo_val_r)
        else $error("readback differs from written value");
    a_test_entry: assert property ($rose(O_TEST_MODE) |-> $past(hi_wr, 2))
        else $error("test mode without nonzero upper write");
    // the host never touches the upper byte, so test mode stays off
    a_upper_clear: assert property (!O_TEST_MODE)
        else $error("test mode entered on the host link");
    c_update: cover property (ccs_wr ##1 gpo_rd ##2 gpo_wr);
    c_read: cover property (gpo_rd);
    c_pins: cover property (O_GPO != ZERO_BYTE);
endmodule
`default_nettype wire

/* File: scan_ctrl_dev.sv */
// Implementation choice: the address-and-strobe port.
`default_nettype none
module scan_ctrl_dev
    import scan_ctrl_pkg::*;
(
    input  wire logic       I_CLK,
    input  wire logic       I_RESET,
    input  wire logic       I_CE,
    scan_ctrl_if.dev        bus,
    input  wire logic       I_MODE_DONE,
    input  wire logic       I_UC_GPO0,
    output logic [7:0]      O_GPO,
    output logic [5:0]      O_SAT_GAIN,
    output logic [3:0]      O_FLICKER,
    output logic            O_BARS,
    output logic            O_CENTRE,
    output logic            O_TEST_MODE,
    output logic            O_UC_RUN,
    output logic            O_SWRST,
    output logic            O_REDETECT,
    output logic            O_RECAL,
    output logic            O_TBL_RESET,
    output logic            O_RECOMPUTE,
    output logic            O_TBL_STORE,
    output logic            O_CAL_SAMPLE,
    output logic            O_DET_SAMPLE,
    output logic            O_MCAL_TAKE,
    output logic            O_MODE_DONE
);
    // =======================================================
    // storage
    // =======================================================
    typedef enum logic [1:0] {UC_IDLE = 2'b00, UC_BUSY = 2'b01, UC_DONE = 2'b11} uc_type;
    logic [5:0] sat_r;          // saturation coefficient
    logic [7:0] gpo_r;          // general output register, as written
    logic [7:0] gpo_hi_r;       // reserved upper byte
    logic [7:0] ccs_gpo_r;      // command-space copy of outputs
    logic [7:0] cmd_lo_r;       // command word low
    logic [7:0] cmd_hi_r;       // command word high
    logic       done_r;         // mode change done flag
    logic [7:0] rdata_r;        // read data register
    logic [7:0] pend_r;         // command bit being serviced
    logic [3:0] cnt_r;          // service countdown
    uc_type     uc_r;           // controller service state
    logic       sync1_r;        // mode-done pin sync stage 1
    logic       sync2_r;        // mode-done pin sync stage 2
    logic       g1_r;           // controller output bit sync 1
    logic       g2_r;           // controller output bit sync 2
    logic       done_q_r;       // delayed sync for edge detect

    // =======================================================
    // decode
    // =======================================================
    wire       wr_sat  = bus.wr && bus.addr == ADDR_SAT_LO;
    wire       wr_gpo  = bus.wr && bus.addr == ADDR_GPO_LO;
    wire       wr_gph  = bus.wr && bus.addr == ADDR_GPO_HI;
    wire       wr_clo  = bus.wr && bus.addr == ADDR_CMD_LO;
    wire       wr_chi  = bus.wr && bus.addr == ADDR_CMD_HI;
    wire       uc_on   = cmd_lo_r[BIT_UC_EN];
    wire       done_ev = sync2_r && !done_q_r;
    // lowest pending self-clearing bit of the low byte; the high byte's bit only when low has none
    wire [7:0] req_lo  = cmd_lo_r & SELF_CLR_LO;
    wire [7:0] req_hi  = cmd_hi_r & SELF_CLR_HI;
    wire [7:0] pick_lo = req_lo & (~req_lo + 8'h01);
    wire       take_hi = (req_lo == ZERO_BYTE) && (req_hi != ZERO_BYTE);
    // clear the serviced bit as the service finishes
    wire       finish  = (uc_r == UC_DONE);
    wire [7:0] rd_mux  =
        (bus.addr == ADDR_SAT_LO) ? {2'b00, sat_r} :
        (bus.addr == ADDR_GPO_LO) ? gpo_r :
        (bus.addr == ADDR_GPO_HI) ? gpo_hi_r :
        (bus.addr == ADDR_CMD_LO) ? cmd_lo_r :
        (bus.addr == ADDR_CMD_HI) ? cmd_hi_r : ZERO_BYTE;
    // the high byte reuses pend_r bit positions; mark it with pend_hi_r flag
    logic pend_hi_r;            // serviced bit lives in the high byte

    // =======================================================
    // synchronisers for the controller's own inputs
    // =======================================================
    always_ff @(posedge I_CLK)
    begin
        if (I_RESET)
        begin
            sync1_r  <= 1'b0;
            sync2_r  <= 1'b0;
            done_q_r <= 1'b0;
            g1_r     <= 1'b0;
            g2_r     <= 1'b0;
        end
        else if (I_CE)
        begin
            sync1_r  <= I_MODE_DONE;
            sync2_r  <= sync1_r;
            done_q_r <= sync2_r;
            g1_r     <= I_UC_GPO0;
            g2_r     <= g1_r;
        end
    end

    // =======================================================
    // host-written registers
    // =======================================================
    always_ff @(posedge I_CLK)
    begin
        if (I_RESET)
        begin
            sat_r     <= 6'h00;
            gpo_r     <= ZERO_BYTE;
            gpo_hi_r  <= ZERO_BYTE;
            ccs_gpo_r <= ZERO_BYTE;
            rdata_r   <= ZERO_BYTE;
        end
        else if (I_CE)
        begin
            if (wr_sat)
                sat_r <= bus.wdata[5:0] & SAT_MASK;
            if (bus.ccs_wr && bus.addr == CCS_GPO_ENTRY)
                ccs_gpo_r <= bus.wdata & ~GPO_BIT0;
            if (wr_gpo)
                gpo_r <= bus.wdata;
            if (wr_gph)
                gpo_hi_r <= bus.wdata;
            if (bus.rd)
                rdata_r <= rd_mux;
        end
    end

    // =======================================================
    // command words: host sets, controller clears, set wins
    // =======================================================
    always_ff @(posedge I_CLK)
    begin
        if (I_RESET)
        begin
            cmd_lo_r <= ZERO_BYTE;
            cmd_hi_r <= ZERO_BYTE;
        end
        else if (I_CE)
        begin
            if (wr_clo)
                cmd_lo_r <= bus.wdata;
            else if (finish && !pend_hi_r)
                cmd_lo_r <= cmd_lo_r & ~pend_r;
            if (wr_chi)
                cmd_hi_r <= bus.wdata;
            else if (finish && pend_hi_r)
                cmd_hi_r <= cmd_hi_r & ~pend_r;
        end
    end

    // =======================================================
    // controller model: one command at a time, fixed service
    // =======================================================
    always_ff @(posedge I_CLK)
    begin
        if (I_RESET)
        begin
            uc_r      <= UC_IDLE;
            pend_r    <= ZERO_BYTE;
            pend_hi_r <= 1'b0;
            cnt_r     <= 4'h0;
        end
        else if (I_CE)
        begin
            case (uc_r)
                UC_IDLE:
                begin
                    if (uc_on && (req_lo != ZERO_BYTE || take_hi))
                    begin
                        pend_r    <= take_hi ? req_hi : pick_lo;
                        pend_hi_r <= take_hi;
                        cnt_r     <= CMD_CYCLES;
                        uc_r      <= UC_BUSY;
                    end
                end
                UC_BUSY:
                begin
                    cnt_r <= cnt_r - 4'h1;
                    if (cnt_r == 4'h1)
                        uc_r <= UC_DONE;
                end
                UC_DONE:
                begin
                    pend_r    <= ZERO_BYTE;
                    pend_hi_r <= 1'b0;
                    uc_r      <= UC_IDLE;
                end
                default:
                    uc_r <= UC_IDLE;
            endcase
        end
    end

    // =======================================================
    // done flag and registered outputs
    // =======================================================
    wire start = (uc_r == UC_IDLE) && uc_on && (req_lo != ZERO_BYTE || take_hi);
    wire [7:0] start_bit = take_hi ? ZERO_BYTE : pick_lo;
    always_ff @(posedge I_CLK)
    begin
        if (I_RESET)
        begin
            done_r       <= 1'b0;
            O_GPO        <= ZERO_BYTE;
            O_SAT_GAIN   <= 6'h00;
            O_FLICKER    <= 4'h0;
            O_BARS       <= 1'b0;
            O_CENTRE     <= 1'b0;
            O_TEST_MODE  <= 1'b0;
            O_UC_RUN     <= 1'b0;
            O_SWRST      <= 1'b0;
            O_REDETECT   <= 1'b0;
            O_RECAL      <= 1'b0;
            O_TBL_RESET  <= 1'b0;
            O_RECOMPUTE  <= 1'b0;
            O_TBL_STORE  <= 1'b0;
            O_CAL_SAMPLE <= 1'b0;
            O_DET_SAMPLE <= 1'b0;
            O_MCAL_TAKE  <= 1'b0;
            O_MODE_DONE  <= 1'b0;
        end
        else if (I_CE)
        begin
            if (done_ev)
                done_r <= 1'b1;
            else if (start && start_bit[BIT_CLRDONE])
                done_r <= 1'b0;
            O_MODE_DONE  <= done_r;
            O_GPO        <= {gpo_r[7:1], uc_on ? g2_r : gpo_r[0]};
            O_SAT_GAIN   <= sat_r;
            O_FLICKER    <= (cmd_hi_r[FLK_MSB:FLK_LSB] > FLK_MAX)
                            ? FLK_MAX : cmd_hi_r[FLK_MSB:FLK_LSB];
            O_BARS       <= cmd_lo_r[BIT_BARS];
            O_CENTRE     <= cmd_hi_r[BIT_CENTRE];
            O_TEST_MODE  <= gpo_hi_r != ZERO_BYTE;
            O_UC_RUN     <= uc_on;
            O_SWRST      <= start && start_bit[BIT_SWRST];
            O_REDETECT   <= start && start_bit[BIT_REDET];
            O_RECAL      <= start && (start_bit[BIT_RECAL] || start_bit[BIT_REDET]);
            O_TBL_RESET  <= start && start_bit[BIT_RECAL] && cmd_lo_r[BIT_TBL_EN];
            O_RECOMPUTE  <= start && start_bit[BIT_RECOMP];
            O_TBL_STORE  <= cmd_lo_r[BIT_TBL_EN];
            O_CAL_SAMPLE <= uc_on && !cmd_hi_r[BIT_CAL_BYP];
            O_DET_SAMPLE <= uc_on && !cmd_hi_r[BIT_DET_BYP];
            O_MCAL_TAKE  <= start && take_hi;
        end
    end

    assign bus.rdata = rdata_r;
endmodule
`default_nettype wire

/* File: scan_ctrl_host.sv */
`default_nettype none
module scan_ctrl_host
    import scan_ctrl_pkg::*;
(
    input  wire logic       I_CLK,
    input  wire logic       I_RESET,
    input  wire logic       I_CE,
    input  wire logic [1:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic [7:0]      o_rdata,
    scan_ctrl_if.host       bus
);
    // =======================================================
    // host sequencer: gpo update = entry write, rmw of register
    // =======================================================
    typedef enum logic [2:0] {H_IDLE = 3'b000, H_CCS = 3'b001, H_RD = 3'b011,
                              H_WAIT = 3'b010, H_WR = 3'b110} hst_type;
    hst_type    st_r;       // sequencer state
    logic [7:0] val_r;      // value to place on outputs
    logic [7:0] rd_r;       // last read-back
    logic       wr_r;       // strobes toward device
    logic       rd_o_r;
    logic       ccs_r;
    logic [7:0] a_r;
    logic [7:0] d_r;
    logic [7:0] o_r;        // host read data

    wire busy = st_r != H_IDLE;
    wire go   = i_wr && i_addr == HOST_ADDR_GO && !busy;

    always_ff @(posedge I_CLK)
    begin
        if (I_RESET)
        begin
            st_r <= H_IDLE;
            val_r <= ZERO_BYTE;
            rd_r <= ZERO_BYTE;
            wr_r <= 1'b0;
            rd_o_r <= 1'b0;
            ccs_r <= 1'b0;
            a_r <= ZERO_BYTE;
            d_r <= ZERO_BYTE;
            o_r <= ZERO_BYTE;
        end
        else if (I_CE)
        begin
            wr_r <= 1'b0;
            rd_o_r <= 1'b0;
            ccs_r <= 1'b0;
            if (i_wr && i_addr == HOST_ADDR_DATA)
                val_r <= i_wdata;
            if (i_rd)
                o_r <= (i_addr == HOST_ADDR_DATA) ? val_r :
                       (i_addr == HOST_ADDR_STAT) ? {7'h00, busy} :
                       (i_addr == HOST_ADDR_RDAT) ? rd_r : ZERO_BYTE;
            case (st_r)
                H_IDLE:
                    if (go)
                        st_r <= H_CCS;
                H_CCS:
                begin
                    ccs_r <= 1'b1;
                    a_r <= CCS_GPO_ENTRY;
                    d_r <= val_r;
                    st_r <= H_RD;
                end
                H_RD:
                begin
                    rd_o_r <= 1'b1;
                    a_r <= ADDR_GPO_LO;
                    st_r <= H_WAIT;
                end
                H_WAIT:
                    st_r <= H_WR;
                H_WR:
                begin
                    rd_r <= bus.rdata;
                    wr_r <= 1'b1;
                    a_r <= ADDR_GPO_LO;
                    d_r <= (val_r & ~GPO_BIT0) | (bus.rdata & GPO_BIT0);
                    st_r <= H_IDLE;
                end
                default:
                    st_r <= H_IDLE;
            endcase
        end
    end

    assign bus.wr     = wr_r;
    assign bus.rd     = rd_o_r;
    assign bus.ccs_wr = ccs_r;
    assign bus.addr   = a_r;
    assign bus.wdata  = d_r;
    assign o_rdata    = o_r;
endmodule
`default_nettype wire

/* File: scan_ctrl_if.sv */
`default_nettype none
// register port between host and converter
interface scan_ctrl_if;
    logic       wr;      // write strobe
    logic       rd;      // read strobe
    logic [7:0] addr;    // register address
    logic [7:0] wdata;   // write data
    logic [7:0] rdata;   // read data, cycle after rd
    logic       ccs_wr;  // config command space write
    modport dev  (input wr, rd, addr, wdata, ccs_wr, output rdata);
    modport host (output wr, rd, addr, wdata, ccs_wr, input rdata);
endinterface
`default_nettype wire

/* File: scan_ctrl_pkg.sv */
`default_nettype none
package scan_ctrl_pkg;
    // register byte addresses on the serial control port
    localparam logic [7:0] ADDR_SAT_LO      = 8'h2E;
    localparam logic [7:0] ADDR_SAT_HI      = 8'h2F;
    localparam logic [7:0] ADDR_GPO_LO      = 8'h34;
    localparam logic [7:0] ADDR_GPO_HI      = 8'h35;
    localparam logic [7:0] ADDR_CMD_LO      = 8'h60;
    localparam logic [7:0] ADDR_CMD_HI      = 8'h61;
    // config command space entry for the general outputs
    localparam logic [7:0] CCS_GPO_ENTRY    = 8'h20;
    // command-low field positions
    localparam int BIT_SWRST    = 0;
    localparam int BIT_UC_EN    = 1;
    localparam int BIT_BARS     = 2;
    localparam int BIT_CLRDONE  = 3;
    localparam int BIT_REDET    = 4;
    localparam int BIT_RECAL    = 5;
    localparam int BIT_RECOMP   = 6;
    localparam int BIT_TBL_EN   = 7;
    // command-high field positions
    localparam int BIT_CAL_BYP  = 0;
    localparam int BIT_DET_BYP  = 1;
    localparam int BIT_CENTRE   = 2;
    localparam int BIT_MCAL_NEW = 3;
    localparam int FLK_LSB      = 4;
    localparam int FLK_MSB      = 7;
    // self-clearing command bits of each command byte
    localparam logic [7:0] SELF_CLR_LO = 8'h79;
    localparam logic [7:0] SELF_CLR_HI = 8'h08;
    // values
    localparam logic [7:0] ZERO_BYTE   = 8'h00;
    localparam logic [5:0] SAT_MASK    = 6'h3F;
    localparam logic [3:0] FLK_MAX     = 4'h8;
    localparam logic [7:0] GPO_BIT0    = 8'h01;
    // cycles the controller model spends on each command
    localparam logic [3:0] CMD_CYCLES  = 4'h4;
    // host-side register map for its own command port
    localparam logic [1:0] HOST_ADDR_DATA = 2'h0;
    localparam logic [1:0] HOST_ADDR_GO   = 2'h1;
    localparam logic [1:0] HOST_ADDR_STAT = 2'h2;
    localparam logic [1:0] HOST_ADDR_RDAT = 2'h3;
endpackage
`default_nettype wire
